// ### pkg/swmcs_defines.vh
// Constants for the serial wire mode and clock select block
`ifndef SWMCS_DEFINES_VH
`define SWMCS_DEFINES_VH
// Wire mode field encodings
`define SWMCS_WM_OFF 2'h0
`define SWMCS_WM_THREE 2'h1
`define SWMCS_WM_TWO 2'h2
`define SWMCS_WM_TWO_HOLD 2'h3
// Clock source field encodings
`define SWMCS_CS_STROBE 2'h0
`define SWMCS_CS_TIMER 2'h1
`define SWMCS_CS_EXT_POS 2'h2
`define SWMCS_CS_EXT_NEG 2'h3
// Field positions within the control byte
`define SWMCS_CTRL_TC_BIT 0
`define SWMCS_CTRL_CLK_BIT 1
`define SWMCS_CTRL_CS_LSB 2
`define SWMCS_CTRL_WM_LSB 4
// Reset values and counter maximum
`define SWMCS_RST_BYTE 8'h00
`define SWMCS_RST_CNT 4'h0
`define SWMCS_CNT_MAX 4'hf
`endif

// ### hw/swmcs_core.v
// Wire mode output steering and clock source selection for the serial unit
//
// Overview of operation
// - Mode 00 disables serial outputs, clock hold and start detector.
// - Inputs always work; shift and count clocks remain available in every mode.
// - Three-wire: shift MSB replaces port bit; direction bit still sets direction.
// - Three-wire leaves input and clock pins as ordinary port pins.
// - Two-wire: data and clock pins open-drain, enabled by direction bits.
// - Data line pulled low when shift MSB or port bit is zero.
// - Clock line pulled low when port bit zero or start hold active.
// - Start condition holds clock low until start flag cleared.
// - Two-wire keeps pin inputs and disables both pull-ups.
// - Mode 11 also holds clock low from overflow until flag cleared.
// - External clock: output changes on edge opposite to sampling edge.
// - Strobe or timer clock: output latch transparent.
// - Select 00: one shift and count per strobe write, none otherwise.
// - Select 01: timer compare match clocks shift register and counter.
// - Select 10/11: shift on rising/falling edge; counter on both edges.
// - External with strobe bit set: counter clocked only by toggle writes.
// - Toggle write inverts the clock pin port value regardless of direction.
// - Counter wrap from 15 to 0 sets the overflow flag.
`include "swmcs_defines.vh"
module swmcs_core (
  input wire i_clock,
  input wire i_reset_n,
  // Control byte write: wire mode, clock source, strobe and toggle bits
  input wire i_ctrl_wr,
  input wire [7:0] i_ctrl_wdata,
  // Data register write
  input wire i_data_wr,
  input wire [7:0] i_data_wdata,
  // Counter write
  input wire i_cnt_wr,
  input wire [3:0] i_cnt_wdata,
  // Flag clears, write one to clear
  input wire i_start_flag_clr,
  input wire i_ovf_flag_clr,
  // Timer compare match pulse, same clock
  input wire i_timer_match,
  // General-purpose port and direction bits of data and clock pins
  input wire i_data_port,
  input wire i_data_dir,
  input wire i_clk_dir,
  // Pins from outside
  input wire i_serial_in_pin,
  input wire i_serial_clk_pin,
  // Data output pin
  output reg o_data_out,
  output reg o_data_oe,
  output reg o_data_pullup,
  // Clock pin
  output reg o_clk_out,
  output reg o_clk_oe,
  output reg o_clk_pullup,
  // Status
  output reg [7:0] o_shift_data,
  output reg [3:0] o_cnt,
  output reg o_start_cond_flag,
  output reg o_cnt_ovf_flag,
  output reg [1:0] o_wire_mode_sel,
  output reg [1:0] o_clk_src_sel,
  output reg o_clk_strobe_bit,
  output reg o_clk_port
);

  // ==========================================================
  // Control state
  // ==========================================================
  reg [1:0] wire_mode_sel;
  reg [1:0] clk_src_sel;
  reg clk_strobe_bit;
  reg clk_port;
  reg [7:0] shift_reg;
  reg [3:0] cnt;
  reg start_cond_flag;
  reg cnt_ovf_flag;
  reg out_latch;
  // Open during the first half of an external clock cycle
  reg latch_open;
  reg start_hold;
  reg ovf_hold;
  reg data_sync1, data_sync2;
  reg clk_sync1, clk_sync2, clk_prev;
  reg data_prev;

  wire strobe_wr = i_ctrl_wr & i_ctrl_wdata[`SWMCS_CTRL_CLK_BIT];
  wire toggle_wr = i_ctrl_wr & i_ctrl_wdata[`SWMCS_CTRL_TC_BIT];
  wire two_wire = wire_mode_sel[1];

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // Only the second stage is ever read, keeping metastability contained
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_sync1 <= 1'b1;
      data_sync2 <= 1'b1;
      // Idle level of the pulled-up clock line, so no false edge follows reset
      clk_sync1 <= 1'b1;
      clk_sync2 <= 1'b1;
      clk_prev <= 1'b1;
      data_prev <= 1'b1;
    end else begin
      data_sync1 <= i_serial_in_pin;
      data_sync2 <= data_sync1;
      clk_sync1 <= i_serial_clk_pin;
      clk_sync2 <= clk_sync1;
      clk_prev <= clk_sync2;
      data_prev <= data_sync2;
    end
  end

  wire ext_rise = clk_sync2 & ~clk_prev;
  wire ext_fall = ~clk_sync2 & clk_prev;
  // Start condition: data falls while clock high, detector off in mode 00
  wire start_det = two_wire & data_prev & ~data_sync2 & clk_sync2;

  // ==========================================================
  // Clock source selection
  // ==========================================================
  reg shift_tick;
  reg cnt_tick;
  always @* begin
    shift_tick = 1'b0;
    cnt_tick = 1'b0;
    case (clk_src_sel)
      `SWMCS_CS_STROBE: begin
        shift_tick = strobe_wr;
        cnt_tick = strobe_wr;
      end
      `SWMCS_CS_TIMER: begin
        shift_tick = i_timer_match;
        cnt_tick = i_timer_match;
      end
      `SWMCS_CS_EXT_POS: begin
        shift_tick = ext_rise;
        cnt_tick = clk_strobe_bit ? toggle_wr : (ext_rise | ext_fall);
      end
      `SWMCS_CS_EXT_NEG: begin
        shift_tick = ext_fall;
        cnt_tick = clk_strobe_bit ? toggle_wr : (ext_rise | ext_fall);
      end
      default: begin
        shift_tick = 1'b0;
        cnt_tick = 1'b0;
      end
    endcase
  end

  // Sampling edge of the external clock; output latch closes on it
  wire sample_edge = (clk_src_sel == `SWMCS_CS_EXT_NEG) ? ext_fall : ext_rise;
  wire opposite_edge = (clk_src_sel == `SWMCS_CS_EXT_NEG) ? ext_rise : ext_fall;
  wire [3:0] next_cnt = cnt + 4'h1;
  wire cnt_wrap = cnt_tick & (cnt == `SWMCS_CNT_MAX) & ~i_cnt_wr;
  wire next_msb = i_data_wr ? i_data_wdata[7] : (shift_tick ? shift_reg[6] : shift_reg[7]);

  // ==========================================================
  // Control, shift register, counter and flags
  // ==========================================================
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wire_mode_sel <= 2'h0;
      clk_src_sel <= 2'h0;
      clk_strobe_bit <= 1'b0;
      clk_port <= 1'b0;
      shift_reg <= 8'h00;
      cnt <= `SWMCS_RST_CNT;
      start_cond_flag <= 1'b0;
      cnt_ovf_flag <= 1'b0;
      out_latch <= 1'b0;
      start_hold <= 1'b0;
      ovf_hold <= 1'b0;
    end else begin
      if (i_ctrl_wr) begin
        wire_mode_sel <= i_ctrl_wdata[`SWMCS_CTRL_WM_LSB +: 2];
        clk_src_sel <= i_ctrl_wdata[`SWMCS_CTRL_CS_LSB +: 2];
        // Strobe bit persists only as a select with external clock
        clk_strobe_bit <= i_ctrl_wdata[`SWMCS_CTRL_CLK_BIT] & i_ctrl_wdata[`SWMCS_CTRL_CS_LSB + 1];
      end
      // Toggle flips port value whatever the direction bit says
      if (toggle_wr)
        clk_port <= ~clk_port;
      // A written value beats a simultaneous shift
      if (i_data_wr)
        shift_reg <= i_data_wdata;
      else if (shift_tick)
        shift_reg <= {shift_reg[6:0], data_sync2};
      if (i_cnt_wr)
        cnt <= i_cnt_wdata;
      else if (cnt_tick)
        cnt <= next_cnt;
      // Set wins over clear for both flags
      if (cnt_wrap)
        cnt_ovf_flag <= 1'b1;
      else if (i_ovf_flag_clr)
        cnt_ovf_flag <= 1'b0;
      if (start_det)
        start_cond_flag <= 1'b1;
      else if (i_start_flag_clr)
        start_cond_flag <= 1'b0;
      // Clock hold after start until flag cleared, only when output enabled
      if (start_det & i_clk_dir)
        start_hold <= 1'b1;
      else if (i_start_flag_clr | ~two_wire)
        start_hold <= 1'b0;
      // Overflow hold in mode 11 until overflow flag cleared
      if (cnt_wrap & (wire_mode_sel == `SWMCS_WM_TWO_HOLD))
        ovf_hold <= 1'b1;
      else if (i_ovf_flag_clr | (wire_mode_sel != `SWMCS_WM_TWO_HOLD))
        ovf_hold <= 1'b0;
      // Latch follows MSB on opposite edge; holds across the sampling edge
      if (!clk_src_sel[1])
        out_latch <= next_msb;
      else if (opposite_edge | ~sample_edge & latch_open)
        out_latch <= next_msb;
    end
  end

  // Latch open during first half of external clock cycle
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n)
      latch_open <= 1'b1;
    else if (sample_edge)
      latch_open <= 1'b0;
    else if (opposite_edge)
      latch_open <= 1'b1;
  end

  // Internal clocks see the new MSB in the same cycle it is made
  wire serial_out = clk_src_sel[1] ? out_latch : next_msb;

  // ==========================================================
  // Pin output steering
  // ==========================================================
  // Registered outputs trade one cycle of delay for glitch-free pins
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_data_out <= 1'b0;
      o_data_oe <= 1'b0;
      o_data_pullup <= 1'b0;
      o_clk_out <= 1'b0;
      o_clk_oe <= 1'b0;
      o_clk_pullup <= 1'b0;
    end else begin
      case (wire_mode_sel)
        `SWMCS_WM_OFF: begin
          o_data_out <= i_data_port;
          o_data_oe <= i_data_dir;
          o_data_pullup <= ~i_data_dir & i_data_port;
          o_clk_out <= clk_port;
          o_clk_oe <= i_clk_dir;
          o_clk_pullup <= ~i_clk_dir & clk_port;
        end
        `SWMCS_WM_THREE: begin
          o_data_out <= serial_out;
          o_data_oe <= i_data_dir;
          o_data_pullup <= ~i_data_dir & i_data_port;
          o_clk_out <= clk_port;
          o_clk_oe <= i_clk_dir;
          o_clk_pullup <= ~i_clk_dir & clk_port;
        end
        default: begin
          // Open drain: only ever drive low
          o_data_out <= 1'b0;
          o_data_oe <= i_data_dir & (~serial_out | ~i_data_port);
          o_data_pullup <= 1'b0;
          o_clk_out <= 1'b0;
          o_clk_oe <= i_clk_dir & (~clk_port | start_hold | ovf_hold);
          o_clk_pullup <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Status outputs
  // ==========================================================
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_shift_data <= 8'h00;
      o_cnt <= 4'h0;
      o_start_cond_flag <= 1'b0;
      o_cnt_ovf_flag <= 1'b0;
      o_wire_mode_sel <= 2'h0;
      o_clk_src_sel <= 2'h0;
      o_clk_strobe_bit <= 1'b0;
      o_clk_port <= 1'b0;
    end else begin
      o_shift_data <= shift_reg;
      o_cnt <= cnt;
      o_start_cond_flag <= start_cond_flag;
      o_cnt_ovf_flag <= cnt_ovf_flag;
      o_wire_mode_sel <= wire_mode_sel;
      o_clk_src_sel <= clk_src_sel;
      o_clk_strobe_bit <= clk_strobe_bit;
      o_clk_port <= clk_port;
    end
  end

endmodule // swmcs_core

// ### dv/swmcs_properties.sv
// Checker for wire mode pin steering and counter clocking
`include "swmcs_defines.vh"
module swmcs_checker (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_ctrl_wr,
  input wire [7:0] i_ctrl_wdata,
  input wire i_cnt_wr,
  input wire i_timer_match,
  input wire i_data_port,
  input wire i_data_dir,
  input wire i_clk_dir,
  input wire o_data_out,
  input wire o_data_oe,
  input wire o_data_pullup,
  input wire o_clk_out,
  input wire o_clk_oe,
  input wire o_clk_pullup,
  input wire [7:0] o_shift_data,
  input wire [3:0] o_cnt,
  input wire o_start_cond_flag,
  input wire o_cnt_ovf_flag,
  input wire [1:0] o_wire_mode_sel,
  input wire [1:0] o_clk_src_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // ==========
  // Pin steering; status copies and pins share one cycle of lag
  off_data_a: assert property (o_wire_mode_sel == `SWMCS_WM_OFF |-> o_data_out == $past(i_data_port))
    else $error("data pin left port control");
  pullup_off_a: assert property (o_wire_mode_sel[1] |-> !o_data_pullup && !o_clk_pullup)
    else $error("pull-up on in two-wire");
  sda_enable_a: assert property (o_wire_mode_sel[1] && !$past(i_data_dir) |-> !o_data_oe)
    else $error("data driver on without direction");
  open_drain_a: assert property (o_wire_mode_sel[1] |-> !o_data_out && !o_clk_out)
    else $error("open-drain pin driven high");
  sda_level_a: assert property (o_wire_mode_sel[1] && $past(i_data_dir) && !$past(i_data_port)
    |-> o_data_oe) else $error("data line not pulled low");
  start_hold_a: assert property (o_wire_mode_sel[1] && $rose(o_start_cond_flag)
    && $past(i_clk_dir, 2) && $past(i_clk_dir) |-> o_clk_oe) else $error("clock not held on start");
  ovf_hold_a: assert property (o_wire_mode_sel == `SWMCS_WM_TWO_HOLD
    && $past(o_wire_mode_sel) == `SWMCS_WM_TWO_HOLD && $rose(o_cnt_ovf_flag) && $past(i_clk_dir)
    |-> o_clk_oe) else $error("clock not held on overflow");
  // ==========
  // Counter clocking
  strobe_count_a: assert property (i_ctrl_wr && i_ctrl_wdata[3:1] == 3'h1 && !i_cnt_wr
    && o_clk_src_sel == `SWMCS_CS_STROBE && !$past(i_ctrl_wr)
    |-> ##2 o_cnt == $past(o_cnt) + 4'h1) else $error("strobe did not count once");
  timer_count_a: assert property (o_clk_src_sel == `SWMCS_CS_TIMER && !$past(i_ctrl_wr)
    && i_timer_match && !i_cnt_wr |-> ##2 o_cnt == $past(o_cnt) + 4'h1) else $error("match did not count");
  ovf_set_a: assert property (o_cnt == 4'h0 && $past(o_cnt) == 4'hf && !$past(i_cnt_wr, 2)
    |-> o_cnt_ovf_flag) else $error("wrap without overflow flag");
  cover property (o_wire_mode_sel[1] && o_start_cond_flag);
  cover property (o_wire_mode_sel == `SWMCS_WM_TWO_HOLD && o_cnt_ovf_flag);
  cover property (o_clk_src_sel[1] && o_cnt == 4'h4);
endmodule // swmcs_checker
bind swmcs_core swmcs_checker chk_i (.*);

// ### dv/swmcs_peer.sv
// Far-side serial peer: link clock and wired-AND data line
module swmcs_peer (
  input wire i_data_out,
  input wire i_data_oe,
  input wire i_clk_out,
  input wire i_clk_oe,
  output wire o_data_pin,
  output wire o_clk_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic link_clk = 1'b1;
  logic data_low = 1'b0;
  // Open-drain lines: either party pulls low, pull-up otherwise
  assign o_data_pin = !data_low && !(i_data_oe && !i_data_out);
  assign o_clk_pin = link_clk && !(i_clk_oe && !i_clk_out);
  // Clock pulses only within a frame, idle high between; odd offset breaks phase lock
  task automatic frame(input int n);
    #130;
    repeat (n) #400 link_clk = ~link_clk;
  endtask
endmodule // swmcs_peer

// ### dv/test_swmcs_core.sv
// Self-checking bench for the wire mode and clock select block
module test_swmcs_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock, i_reset_n, i_data_port, i_data_dir, i_clk_dir;
  logic [5:0] stb;
  logic [7:0] i_ctrl_wdata, i_data_wdata;
  logic [3:0] i_cnt_wdata;
  wire i_ctrl_wr, i_data_wr, i_cnt_wr, i_start_flag_clr, i_ovf_flag_clr, i_timer_match, s_in, s_clk;
  wire o_data_out, o_data_oe, o_data_pullup, o_clk_out, o_clk_oe, o_clk_pullup;
  wire o_start_cond_flag, o_cnt_ovf_flag, o_clk_strobe_bit, o_clk_port;
  wire [7:0] o_shift_data;
  wire [3:0] o_cnt;
  wire [1:0] o_wire_mode_sel, o_clk_src_sel;
  int checks = 0;
  int error_cnt = 0;
  // One strobe bit per write kind: ctrl, data, count, start clear, overflow clear, timer
  assign {i_timer_match, i_ovf_flag_clr, i_start_flag_clr, i_cnt_wr, i_data_wr, i_ctrl_wr} = stb;
  swmcs_core DUT (.i_serial_in_pin(s_in), .i_serial_clk_pin(s_clk), .*);
  swmcs_peer P (.i_data_out(o_data_out), .i_data_oe(o_data_oe), .i_clk_out(o_clk_out),
    .i_clk_oe(o_clk_oe), .o_data_pin(s_in), .o_clk_pin(s_clk));
  // ==========
  // Clock and helpers
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wr(input int k, input logic [7:0] v);
    @(posedge i_clock);
    stb <= 6'h01 << k;
    i_ctrl_wdata <= v;
    i_data_wdata <= v;
    i_cnt_wdata <= v[3:0];
    @(posedge i_clock);
    stb <= 6'h00;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch
  initial begin
    #5000000;
    error_cnt++;
    conclude();
  end
  // ==========
  // Scenarios
  initial begin
    {i_reset_n, stb, i_data_port, i_data_dir, i_clk_dir} = 0;
    {i_ctrl_wdata, i_data_wdata, i_cnt_wdata} = 0;
    cyc(20);
    i_reset_n <= 1'b1;
    cyc(2);
    chk("mode", o_wire_mode_sel, 8'h00);
    chk("src", o_clk_src_sel, 8'h00);
    // Strobe: one shift in of the idle-high data line, one count
    wr(1, 8'h81);
    wr(0, 8'h02);
    cyc(3);
    chk("shift", o_shift_data, 8'h03);
    chk("cnt", o_cnt, 8'h01);
    chk("stbit", o_clk_strobe_bit, 8'h00);
    // Timer matches across the counter wrap
    wr(2, 8'h0e);
    wr(0, 8'h04);
    wr(5, 8'h00);
    wr(5, 8'h00);
    cyc(3);
    chk("cnt", o_cnt, 8'h00);
    chk("shift", o_shift_data, 8'h0f);
    chk("ovf", o_cnt_ovf_flag, 8'h01);
    wr(4, 8'h00);
    cyc(3);
    chk("ovf", o_cnt_ovf_flag, 8'h00);
    // External edges with outputs off: two shifts, four counts
    for (int i = 0; i < 2; i++) begin
      wr(2, 8'h00);
      wr(1, 8'h00);
      wr(0, i ? 8'h0c : 8'h08);
      P.frame(4);
      cyc(8);
      chk("cnt", o_cnt, 8'h04);
      chk("shift", o_shift_data, 8'h03);
    end
    // Strobe bit as select: only toggle writes count
    wr(2, 8'h00);
    wr(0, 8'h0a);
    P.frame(4);
    cyc(8);
    chk("cnt", o_cnt, 8'h00);
    wr(0, 8'h0b);
    cyc(3);
    chk("cnt", o_cnt, 8'h01);
    chk("port", o_clk_port, 8'h01);
    // Two-wire: drivers, pull-ups, start hold
    {i_data_port, i_data_dir, i_clk_dir} <= 3'h7;
    wr(1, 8'h80);
    wr(0, 8'h20);
    cyc(3);
    chk("doe", o_data_oe, 8'h00);
    chk("dout", o_data_out, 8'h00);
    chk("pullups", {o_data_pullup, o_clk_pullup}, 8'h00);
    wr(1, 8'h00);
    cyc(3);
    chk("dout", o_data_out, 8'h00);
    chk("doe", o_data_oe, 8'h01);
    wr(1, 8'h80);
    cyc(3);
    wr(3, 8'h00);
    cyc(3);
    P.data_low = 1'b1;
    cyc(6);
    chk("start", o_start_cond_flag, 8'h01);
    chk("coe", o_clk_oe, 8'h01);
    P.data_low = 1'b0;
    wr(3, 8'h00);
    cyc(3);
    chk("coe", o_clk_oe, 8'h00);
    // Overflow hold in mode 11
    wr(1, 8'hff);
    wr(2, 8'h0f);
    wr(0, 8'h34);
    wr(5, 8'h00);
    cyc(3);
    chk("coe", o_clk_oe, 8'h01);
    wr(4, 8'h00);
    cyc(3);
    chk("coe", o_clk_oe, 8'h00);
    // Three-wire: shift MSB replaces the port bit
    wr(1, 8'h00);
    wr(0, 8'h10);
    cyc(3);
    chk("dout", o_data_out, 8'h00);
    wr(1, 8'h80);
    cyc(3);
    chk("dout", o_data_out, 8'h01);
    conclude();
  end
endmodule // test_swmcs_core
